// ==== rtl/uab_pkg.sv ====
// shared constants and carrier types for address recognition and baud selection
package uab_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned UAB_ADR_W = 12;
  localparam int unsigned UAB_DAT_W = 32;
  localparam int unsigned UAB_SEL_W = 4;

  // ****************************************************************
  // register indices (byte address is the index times four)
  // ****************************************************************
  localparam logic [9:0] UAB_IDX_SERIAL_CTRL = 10'h098;
  localparam logic [9:0] UAB_IDX_OWN_ADDR = 10'h0a9;
  localparam logic [9:0] UAB_IDX_ADDR_MASK = 10'h0b9;
  localparam logic [9:0] UAB_IDX_TIMER2_CTRL = 10'h0c8;
  localparam logic [9:0] UAB_IDX_BAUD_GEN_CTRL = 10'h09b;
  localparam logic [9:0] UAB_IDX_RELOAD = 10'h09a;
  localparam logic [9:0] UAB_IDX_POWER_CTRL = 10'h087;
  localparam logic [9:0] UAB_IDX_MATCH_STATUS = 10'h09c;
  localparam logic [9:0] UAB_IDX_BCAST_ADDR = 10'h09d;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0] UAB_RST_BYTE = 8'h00;
  localparam int unsigned UAB_SCTL_MODE_LO = 6;
  localparam int unsigned UAB_T2C_TX_T2 = 4;
  localparam int unsigned UAB_T2C_RX_T2 = 5;
  localparam int unsigned UAB_BGC_SPEED = 1;
  localparam int unsigned UAB_BGC_RX_INT = 2;
  localparam int unsigned UAB_BGC_TX_INT = 3;
  localparam int unsigned UAB_BGC_RUN = 4;
  localparam int unsigned UAB_PWR_DOUBLE = 7;
  localparam int unsigned UAB_STS_GIVEN = 0;
  localparam int unsigned UAB_STS_BCAST = 1;
  localparam int unsigned UAB_STS_SEEN = 2;

  // ****************************************************************
  // cycle counts of the rate generator prescaler, and the generator counter top
  // ****************************************************************
  localparam int unsigned UAB_PRE_BASE = 4;
  localparam int unsigned UAB_PRE_SLOW = 6;
  localparam logic [4:0] UAB_PRE_FAST_LAST = 5'(UAB_PRE_BASE - 1);
  localparam logic [4:0] UAB_PRE_SLOW_LAST = 5'(UAB_PRE_BASE * UAB_PRE_SLOW - 1);
  localparam logic [7:0] UAB_GEN_TOP = 8'hff;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef logic [7:0] uab_byte_t;

  typedef struct packed {
    logic [7:0] addr;
    logic given;
    logic broadcast;
  } uab_match_s;

endpackage

// ==== rtl/uab_buf2.sv ====
// small valid/ready buffer that holds received address bytes
module uab_buf2 #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // pointer step with wrap at the last entry
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  // honest full and empty drive both handshakes
  assign in_ready_o = (count_q != FULL);
  assign out_valid_o = (count_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage; head entry is itself a register
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  assign out_data_o = mem_q[rd_ptr_q];

  // pointers and fill level
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= step(wr_ptr_q);
      end
      if (pop)
      begin
        rd_ptr_q <= step(rd_ptr_q);
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/uab_core.sv ====
// address recognition and baud clock selection for the serial port
// Function
// - broadcast address is own address OR mask; zero bits are don't-care
// - reset clears own address and mask, so any address is answered
// - transmit and receive baud clocks are selected independently
// - transmit clock: internal generator, else timer 2, else timer 1
// - receive clock: internal generator, else timer 2, else timer 1
// - selectable baud sources apply only to modes 1 and 3
// - generator is 8-bit counter reloaded on overflow from reload register
// - generator input is clock divided by 4, and by a further 6 unless speed bit set
// - rate double bit doubles the internal generator baud rate
module uab_core (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [uab_pkg::UAB_ADR_W-1:0] ADR_I,
  input wire logic [uab_pkg::UAB_DAT_W-1:0] DAT_I,
  output logic [uab_pkg::UAB_DAT_W-1:0] DAT_O,
  input wire logic [uab_pkg::UAB_SEL_W-1:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire logic TIMER1_OVF_I,
  input wire logic TIMER2_OVF_I,
  input wire logic RX_ADDR_VALID_I,
  input wire uab_pkg::uab_byte_t RX_ADDR_I,
  output logic RX_ADDR_READY_O,
  output logic MATCH_VALID_O,
  output uab_pkg::uab_match_s MATCH_O,
  input wire logic MATCH_READY_I,
  output logic TX_BAUD_TICK_O,
  output logic RX_BAUD_TICK_O
);
  import uab_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic ack_q, wb_req, wr_ok;
  logic [UAB_DAT_W-1:0] dat_q;
  logic [9:0] idx;
  logic own_wr, mask_wr, sctl_wr, t2c_wr, bgc_wr, rld_wr, pwr_wr;
  uab_byte_t own_q, mask_q, sctl_q, t2c_q, bgc_q, rld_q, pwr_q, sts_q;
  uab_byte_t bcast_addr, buf_data, gen_cnt_q;
  logic buf_valid, buf_pop, match_valid_q;
  uab_match_s match_q;
  logic [4:0] presc_q, presc_base, presc_last;
  logic presc_tick, gen_run, gen_ovf, int_tick, mode13;
  logic tx_tick_q, rx_tick_q;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // given address: every bit the mask marks must equal the own address
  function automatic logic given_hit(input uab_byte_t a, input uab_byte_t own,
                                     input uab_byte_t msk);
    given_hit = &(~(a ^ own) | ~msk);
  endfunction

  // broadcast: ones of own|mask must be ones in the address, zeros ignored
  function automatic logic bcast_hit(input uab_byte_t a, input uab_byte_t bc);
    bcast_hit = &(a | ~bc);
  endfunction

  // source priority: internal generator, then timer 2, then timer 1
  function automatic logic pick_src(input logic int_sel, input logic t2_sel,
                                    input logic t1, input logic t2, input logic ig);
    pick_src = int_sel ? ig : (t2_sel ? t2 : t1);
  endfunction

  // read decode shared by every register read
  function automatic uab_byte_t read_reg(input logic [9:0] i, input uab_byte_t own,
                                         input uab_byte_t msk, input uab_byte_t sctl,
                                         input uab_byte_t t2c, input uab_byte_t bgc,
                                         input uab_byte_t rld, input uab_byte_t pwr,
                                         input uab_byte_t sts);
    case (i)
      UAB_IDX_SERIAL_CTRL: read_reg = sctl;
      UAB_IDX_OWN_ADDR: read_reg = own;
      UAB_IDX_ADDR_MASK: read_reg = msk;
      UAB_IDX_TIMER2_CTRL: read_reg = t2c;
      UAB_IDX_BAUD_GEN_CTRL: read_reg = bgc;
      UAB_IDX_RELOAD: read_reg = rld;
      UAB_IDX_POWER_CTRL: read_reg = pwr;
      UAB_IDX_MATCH_STATUS: read_reg = sts;
      UAB_IDX_BCAST_ADDR: read_reg = own | msk;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // ack one cycle after the strobe, dropped the cycle after it is given
  assign wb_req = CYC_I && STB_I;
  assign idx = ADR_I[11:2];
  // a write lands on the edge where the master samples ack
  assign wr_ok = wb_req && ack_q && WE_I && SEL_I[0];
  assign own_wr = wr_ok && (idx == UAB_IDX_OWN_ADDR);
  assign mask_wr = wr_ok && (idx == UAB_IDX_ADDR_MASK);
  assign sctl_wr = wr_ok && (idx == UAB_IDX_SERIAL_CTRL);
  assign t2c_wr = wr_ok && (idx == UAB_IDX_TIMER2_CTRL);
  assign bgc_wr = wr_ok && (idx == UAB_IDX_BAUD_GEN_CTRL);
  assign rld_wr = wr_ok && (idx == UAB_IDX_RELOAD);
  assign pwr_wr = wr_ok && (idx == UAB_IDX_POWER_CTRL);

  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= wb_req && !ack_q;
    end
  end

  // read data captured as ack rises; unmapped reads answer zero
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      dat_q <= '0;
    end
    else if (wb_req && !ack_q)
    begin
      dat_q <= {24'h000000, read_reg(idx, own_q, mask_q, sctl_q, t2c_q, bgc_q,
                                     rld_q, pwr_q, sts_q)};
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // ****************************************************************
  // software registers
  // ****************************************************************
  // address registers start cleared so every bit is a don't-care
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      own_q <= UAB_RST_BYTE;
      mask_q <= UAB_RST_BYTE;
    end
    else
    begin
      if (own_wr)
      begin
        own_q <= DAT_I[7:0];
      end
      if (mask_wr)
      begin
        mask_q <= DAT_I[7:0];
      end
    end
  end

  // mode, source selects and generator settings; serial control beyond the mode is storage
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      sctl_q <= UAB_RST_BYTE;
      t2c_q <= UAB_RST_BYTE;
      bgc_q <= UAB_RST_BYTE;
      rld_q <= UAB_RST_BYTE;
      pwr_q <= UAB_RST_BYTE;
    end
    else
    begin
      if (sctl_wr)
      begin
        sctl_q <= DAT_I[7:0];
      end
      if (t2c_wr)
      begin
        t2c_q <= DAT_I[7:0];
      end
      if (bgc_wr)
      begin
        bgc_q <= DAT_I[7:0];
      end
      if (rld_wr)
      begin
        rld_q <= DAT_I[7:0];
      end
      if (pwr_wr)
      begin
        pwr_q <= DAT_I[7:0];
      end
    end
  end

  // ****************************************************************
  // address recognition
  // ****************************************************************
  // the buffer absorbs a stall by the consumer; its ready reaches the receiver
  uab_buf2 #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_addr_buf (
    .clk_i(CLOCK_I),
    .srst_i(SRST_I),
    .in_valid_i(RX_ADDR_VALID_I),
    .in_ready_o(RX_ADDR_READY_O),
    .in_data_i(RX_ADDR_I),
    .out_valid_o(buf_valid),
    .out_ready_i(!match_valid_q || MATCH_READY_I),
    .out_data_o(buf_data)
  );

  assign buf_pop = buf_valid && (!match_valid_q || MATCH_READY_I);
  assign bcast_addr = own_q | mask_q;

  // result stage; compared against the registers at the moment of the pop
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      match_valid_q <= 1'b0;
      match_q <= '0;
    end
    else if (buf_pop)
    begin
      match_valid_q <= 1'b1;
      match_q.addr <= buf_data;
      match_q.given <= given_hit(buf_data, own_q, mask_q);
      match_q.broadcast <= bcast_hit(buf_data, bcast_addr);
    end
    else if (MATCH_READY_I)
    begin
      match_valid_q <= 1'b0;
    end
  end

  // last result kept readable for software
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      sts_q <= UAB_RST_BYTE;
    end
    else if (buf_pop)
    begin
      sts_q <= '0;
      sts_q[UAB_STS_GIVEN] <= given_hit(buf_data, own_q, mask_q);
      sts_q[UAB_STS_BCAST] <= bcast_hit(buf_data, bcast_addr);
      sts_q[UAB_STS_SEEN] <= 1'b1;
    end
  end

  assign MATCH_VALID_O = match_valid_q;
  assign MATCH_O = match_q;

  // ****************************************************************
  // internal rate generator
  // ****************************************************************
  assign gen_run = bgc_q[UAB_BGC_RUN];
  // divide by 4 always, by a further 6 when the speed bit is low
  assign presc_base = bgc_q[UAB_BGC_SPEED] ? UAB_PRE_FAST_LAST : UAB_PRE_SLOW_LAST;
  // rate double halves the prescale period, so overflows come twice as often
  assign presc_last = pwr_q[UAB_PWR_DOUBLE] ? (presc_base >> 1) : presc_base;
  assign presc_tick = gen_run && (presc_q == presc_last);

  // a baud generator control or power control write restarts the prescaler so no stale count survives
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I || bgc_wr || pwr_wr || !gen_run || presc_tick)
    begin
      presc_q <= 5'h00;
    end
    else
    begin
      presc_q <= presc_q + 5'h01;
    end
  end

  // 8-bit counter, reloaded on overflow; parked on the reload while stopped
  assign gen_ovf = presc_tick && (gen_cnt_q == UAB_GEN_TOP);
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      gen_cnt_q <= UAB_RST_BYTE;
    end
    else if (!gen_run || gen_ovf)
    begin
      gen_cnt_q <= rld_q;
    end
    else if (presc_tick)
    begin
      gen_cnt_q <= gen_cnt_q + 8'h01;
    end
  end

  // every overflow is one 16x sample tick; the baud rate is a sixteenth of it
  assign int_tick = gen_ovf;

  // ****************************************************************
  // baud clock selection
  // ****************************************************************
  // mode 1 and 3 share the low mode bit; other modes get no ticks here
  assign mode13 = sctl_q[UAB_SCTL_MODE_LO];

  // each direction picks its own source from its own select bits
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      tx_tick_q <= 1'b0;
      rx_tick_q <= 1'b0;
    end
    else
    begin
      tx_tick_q <= mode13 && pick_src(bgc_q[UAB_BGC_TX_INT], t2c_q[UAB_T2C_TX_T2],
                                      TIMER1_OVF_I, TIMER2_OVF_I, int_tick);
      rx_tick_q <= mode13 && pick_src(bgc_q[UAB_BGC_RX_INT], t2c_q[UAB_T2C_RX_T2],
                                      TIMER1_OVF_I, TIMER2_OVF_I, int_tick);
    end
  end

  assign TX_BAUD_TICK_O = tx_tick_q;
  assign RX_BAUD_TICK_O = rx_tick_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_reset_clear: assert property (@(posedge CLOCK_I)
    SRST_I |=> (own_q == 8'h00) && (mask_q == 8'h00))
    else $error("address registers not cleared by reset");

  chk_given_result: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    buf_pop |=> MATCH_O.given ==
      (&(~(MATCH_O.addr ^ $past(own_q)) | ~$past(mask_q))))
    else $error("given address result wrong");

  chk_bcast_result: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    buf_pop |=> MATCH_O.broadcast ==
      (&(MATCH_O.addr | ~($past(own_q) | $past(mask_q)))))
    else $error("broadcast result wrong");

  chk_tx_internal: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    mode13 && bgc_q[UAB_BGC_TX_INT] |=> TX_BAUD_TICK_O == $past(int_tick))
    else $error("transmit tick does not follow the internal generator");

  chk_rx_timer1: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    mode13 && !bgc_q[UAB_BGC_RX_INT] && !t2c_q[UAB_T2C_RX_T2]
      |=> RX_BAUD_TICK_O == $past(TIMER1_OVF_I))
    else $error("receive tick does not follow timer 1");

  chk_dir_indep: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    mode13 && !bgc_q[UAB_BGC_TX_INT] && t2c_q[UAB_T2C_TX_T2] && bgc_q[UAB_BGC_RX_INT]
      && TIMER2_OVF_I && !int_tick |=> TX_BAUD_TICK_O && !RX_BAUD_TICK_O)
    else $error("transmit and receive selection not independent");

  chk_mode_gate: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    !mode13 |=> !TX_BAUD_TICK_O && !RX_BAUD_TICK_O)
    else $error("baud tick outside modes 1 and 3");

  chk_gen_reload: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    gen_ovf |=> gen_cnt_q == $past(rld_q))
    else $error("generator not reloaded on overflow");

  chk_fast_div: assert property (@(posedge CLOCK_I)
    disable iff (SRST_I || bgc_wr || pwr_wr)
    presc_tick && bgc_q[UAB_BGC_SPEED] && !pwr_q[UAB_PWR_DOUBLE]
      |=> !presc_tick [*3] ##1 presc_tick)
    else $error("fast prescaler not dividing by four");

  chk_slow_div: assert property (@(posedge CLOCK_I) disable iff (SRST_I || bgc_wr)
    presc_tick && !bgc_q[UAB_BGC_SPEED] |=> !presc_tick [*8])
    else $error("slow prescaler ticking too soon");

  chk_rate_double: assert property (@(posedge CLOCK_I)
    disable iff (SRST_I || bgc_wr || pwr_wr)
    presc_tick && bgc_q[UAB_BGC_SPEED] && pwr_q[UAB_PWR_DOUBLE]
      |=> !presc_tick ##1 presc_tick)
    else $error("rate double not halving the fast prescale period");

endmodule

// ==== testbench/uab_master_model.sv ====
// partner model: master on the shared serial line handing over address bytes
module uab_master_model
  import uab_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output uab_byte_t addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    valid_o = 1'b0;
    addr_o = 8'h00;
  end
  // one byte held until taken; idle data shows the inverse so stale bytes never look fresh
  task automatic send(input uab_byte_t b, input int gap);
    int n;
    begin
      n = 0;
      @(posedge clk_i);
      valid_o <= 1'b1;
      addr_o <= b;
      @(negedge clk_i);
      while (ready_i !== 1'b1 && n < 200)
      begin
        @(negedge clk_i);
        n++;
      end
      @(posedge clk_i);
      valid_o <= 1'b0;
      addr_o <= ~b;
      repeat (gap) @(posedge clk_i);
    end
  endtask
  // all-ones reaches every slave whatever its mask
  task automatic send_all();
    send(8'hff, 0);
  endtask
endmodule

// ==== testbench/uart_addr_match_baud_select_test.sv ====
// self-checking bench for address recognition and baud clock selection
module uart_addr_match_baud_select_test
  import uab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [3:0] sel = 4'h0;
  logic ack, tmr1 = 1'b0, tmr2 = 1'b0, rx_valid, rx_ready, m_valid, m_ready = 1'b0;
  logic tx_tick, rx_tick, stall = 1'b0;
  uab_byte_t rx_addr, rd;
  uab_match_s m_out;
  uab_match_s exp_q[$], got_q[$];
  uab_byte_t subs[5] = '{8'hf0, 8'hf3, 8'hf1, 8'hff, 8'hfb};
  int err_count = 0, checked = 0, cycles = 0, ph1 = 0, ph2 = 0, tx_n = 0, rx_n = 0, i;
  uab_core dut (.CLOCK_I(clk), .SRST_I(srst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
    .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .TIMER1_OVF_I(tmr1),
    .TIMER2_OVF_I(tmr2), .RX_ADDR_VALID_I(rx_valid), .RX_ADDR_I(rx_addr),
    .RX_ADDR_READY_O(rx_ready), .MATCH_VALID_O(m_valid), .MATCH_O(m_out),
    .MATCH_READY_I(m_ready), .TX_BAUD_TICK_O(tx_tick), .RX_BAUD_TICK_O(rx_tick));
  uab_master_model master (.clk_i(clk), .ready_i(rx_ready), .valid_o(rx_valid),
    .addr_o(rx_addr));
  always #50 clk = ~clk;
  // timer overflow pulses at periods 3 and 5, unlike the internal period 4
  always @(posedge clk)
  begin
    ph1 <= (ph1 == 2) ? 0 : ph1 + 1;
    ph2 <= (ph2 == 4) ? 0 : ph2 + 1;
    tmr1 <= (ph1 == 0);
    tmr2 <= (ph2 == 0);
    m_ready <= stall ? 1'b0 : ($urandom_range(0, 3) != 0);
    cycles <= cycles + 1;
    if (cycles > 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  // sampled mid-cycle, away from the launching edge
  always @(negedge clk)
  begin
    if (tx_tick === 1'b1) tx_n++;
    if (rx_tick === 1'b1) rx_n++;
    if (m_valid === 1'b1 && m_ready === 1'b1) got_q.push_back(m_out);
  end
  task automatic bad(input string s);
    err_count++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic cmp_reg(input uab_byte_t g, input uab_byte_t e);
    checked++;
    if (g !== e) bad($sformatf("reg read %h, want %h", g, e));
  endtask
  task automatic cmp_match(input uab_match_s g, input uab_match_s e);
    checked++;
    if (g !== e) bad($sformatf("match %h, want %h", g, e));
  endtask
  task automatic cmp_ticks(input int g, input int e, input int tol);
    checked++;
    if (g < e - tol || g > e + tol) bad($sformatf("ticks %0d, want %0d", g, e));
  endtask
  // classic single cycle: hold everything until ack is seen at a rising edge
  task automatic wb(input logic [9:0] idx, input logic w, input uab_byte_t wd,
                    input logic [3:0] sl, output uab_byte_t r);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat_w <= {24'h0, wd};
      sel <= sl;
      @(negedge clk);
      while (ack !== 1'b1)
      begin
        @(negedge clk);
      end
      @(posedge clk);
      r = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task automatic wr(input logic [9:0] idx, input uab_byte_t d);
    uab_byte_t x;
    wb(idx, 1'b1, d, 4'h1, x);
  endtask
  task automatic rdc(input logic [9:0] idx, input uab_byte_t e);
    uab_byte_t x;
    wb(idx, 1'b0, 8'h00, 4'h0, x);
    cmp_reg(x, e);
  endtask
  // reference: given on masked bits, broadcast on every one of own|mask
  function automatic uab_match_s model(input uab_byte_t a, input uab_byte_t o,
                                       input uab_byte_t m);
    uab_match_s r;
    r.addr = a;
    r.given = (((a ^ o) & m) == 8'h00);
    r.broadcast = ((a & (o | m)) == (o | m));
    return r;
  endfunction
  task automatic addr_run(input uab_byte_t o, input uab_byte_t m, input uab_byte_t a);
    exp_q.push_back(model(a, o, m));
    if (a == 8'hff) master.send_all();
    else master.send(a, $urandom_range(0, 2));
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    while (exp_q.size() > 0 && got_q.size() > 0)
      cmp_match(got_q.pop_front(), exp_q.pop_front());
    if (exp_q.size() != 0) bad("results lost");
    exp_q.delete();
    $display("test address set done");
  endtask
  task automatic baud(input uab_byte_t sc, input uab_byte_t t2, input uab_byte_t bg,
                      input uab_byte_t pw, input uab_byte_t rl, input int etx,
                      input int erx);
    wr(UAB_IDX_SERIAL_CTRL, sc);
    wr(UAB_IDX_TIMER2_CTRL, t2);
    wr(UAB_IDX_POWER_CTRL, pw);
    wr(UAB_IDX_RELOAD, rl);
    wr(UAB_IDX_BAUD_GEN_CTRL, bg);
    repeat (60) @(posedge clk);
    tx_n = 0;
    rx_n = 0;
    repeat (240) @(posedge clk);
    cmp_ticks(tx_n, etx, 1);
    cmp_ticks(rx_n, erx, 1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(79));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdc(UAB_IDX_OWN_ADDR, 8'h00);
    rdc(UAB_IDX_ADDR_MASK, 8'h00);
    rdc(UAB_IDX_BCAST_ADDR, 8'h00);
    rdc(10'h3ff, 8'h00);
    for (i = 0; i < 6; i++) addr_run(8'h00, 8'h00, 8'($urandom));
    drain();
    wr(UAB_IDX_OWN_ADDR, 8'hf1);
    wr(UAB_IDX_ADDR_MASK, 8'hfa);
    wb(UAB_IDX_OWN_ADDR, 1'b1, 8'h5a, 4'he, rd);
    rdc(UAB_IDX_OWN_ADDR, 8'hf1);
    rdc(UAB_IDX_BCAST_ADDR, 8'hfb);
    foreach (subs[k])
      addr_run(8'hf1, 8'hfa, subs[k]);
    for (i = 0; i < 12; i++) addr_run(8'hf1, 8'hfa, 8'($urandom));
    addr_run(8'hf1, 8'hfa, 8'hfb);
    drain();
    rdc(UAB_IDX_MATCH_STATUS, 8'h06);
    // stalled consumer: two buffered plus one held result, then refusal
    stall <= 1'b1;
    for (i = 0; i < 3; i++) addr_run(8'hf1, 8'hfa, 8'hf0 + 8'(i));
    repeat (3) @(posedge clk);
    cmp_reg({7'h0, rx_ready}, 8'h00);
    stall <= 1'b0;
    drain();
    $display("test buffer done");
    // every pairing of the four select bits, sources told apart by period
    for (i = 0; i < 16; i++)
      baud(8'h40, {2'b00, i[1], i[0], 4'h0}, {4'h1, i[2], i[3], 2'b10}, 8'h00, 8'hff,
           240 / (i[2] ? 4 : (i[0] ? 5 : 3)), 240 / (i[3] ? 4 : (i[1] ? 5 : 3)));
    $display("test source select done");
    baud(8'h00, 8'h00, 8'h1e, 8'h80, 8'hff, 0, 0);
    baud(8'h40, 8'h00, 8'h1c, 8'h00, 8'hff, 10, 10);
    baud(8'h40, 8'h00, 8'h1e, 8'h80, 8'hff, 120, 120);
    baud(8'h40, 8'h00, 8'h1e, 8'h00, 8'hfd, 20, 20);
    $display("test rate generator done");
    wrap_up();
  end
endmodule
